// ### swk_pkg.sv
// Package with register map, field layout and timing constants of the wake payload block
package swk_pkg;

   // ----------------------------------------
   // Register addresses (7-bit control port)
   // ----------------------------------------
   localparam logic [6:0] ADDR_LENGTH_CODE   = 7'h36;
   localparam logic [6:0] ADDR_PAYLOAD_7_6   = 7'h37;
   localparam logic [6:0] ADDR_PAYLOAD_5_4   = 7'h38;
   localparam logic [6:0] ADDR_PAYLOAD_3_2   = 7'h39;
   localparam logic [6:0] ADDR_PAYLOAD_1_0   = 7'h3a;
   localparam logic [6:0] ADDR_FD_TOLERANCE  = 7'h3b;
   localparam logic [6:0] ADDR_RX_SELECT     = 7'h3c;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int LEN_CODE_MSB      = 3;
   localparam int FD_ENABLE_BIT     = 0;
   localparam int DOMINANT_FILTER_TIME_LSB     = 1;
   localparam int DOMINANT_FILTER_TIME_MSB     = 3;
   localparam int FD_SUPPRESS_BIT   = 5;
   localparam int RX_SELECT_BIT     = 14;

   // ----------------------------------------
   // Reset values and length limits
   // ----------------------------------------
   localparam logic [15:0] REG_RESET       = 16'h0000;
   localparam logic [3:0]  LEN_CODE_MAX    = 4'h8;
   localparam logic [3:0]  BYTE_COUNT_MAX  = 4'h8;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS      = 100;
   localparam int FILTER_STEP_NS     = 50;
   localparam int FILTER_LONG_NS     = 775;
   localparam int FILTER_LONG_CYC    = (FILTER_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [6:0]  addr;
      logic [15:0] wdata;
   } swk_req_t;

   typedef struct packed {
      logic        valid;
      logic [3:0]  len_code;
   } swk_len_t;

endpackage : swk_pkg

// ### swk_filter_time.sv
// Maps the dominant filter code to a time in ns and a cycle count
`timescale 1ns/1ps
module swk_filter_time (
   input  wire logic [2:0]  filter_code,
   output logic [9:0]       filter_ns,
   output logic [3:0]       filter_cycles
);
   import swk_pkg::*;

   localparam logic [9:0] STEP_NS = 10'(FILTER_STEP_NS);
   localparam logic [9:0] LONG_NS = 10'(FILTER_LONG_NS);
   localparam logic [9:0] PER_NS  = 10'(CLK_PERIOD_NS);

   wire logic [9:0] step_time;
   wire logic [9:0] rounded;

   assign step_time     = (10'(filter_code) + 10'h001) * STEP_NS;
   assign filter_ns     = (filter_code == 3'h7) ? LONG_NS : step_time;
   assign rounded       = (filter_ns + PER_NS - 10'h001) / PER_NS;
   assign filter_cycles = rounded[3:0];

endmodule : swk_filter_time

// ### swk_payload_compare.sv
// Compares received payload bytes in order against the expected bytes
`timescale 1ns/1ps
module swk_payload_compare (
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic        frame_start,
   input  wire logic [3:0]  byte_count,
   input  wire logic [63:0] expected,
   input  wire logic        rx_byte_valid,
   input  wire logic [7:0]  rx_byte,
   output logic             all_match,
   output logic [3:0]       byte_index
);
   import swk_pkg::*;

   logic [3:0] index_reg;
   logic       ok_reg;

   wire logic [7:0] exp_byte;
   wire logic       in_range;

   assign exp_byte   = expected[{index_reg[2:0], 3'h0} +: 8];
   assign in_range   = index_reg < byte_count;
   assign all_match  = ok_reg && (index_reg == byte_count);
   assign byte_index = index_reg;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         index_reg <= 4'h0;
         ok_reg    <= 1'b1;
      end else if (frame_start) begin
         index_reg <= 4'h0;
         ok_reg    <= 1'b1;
      end else if (rx_byte_valid && in_range) begin
         index_reg <= index_reg + 4'h1;
         ok_reg    <= ok_reg && (rx_byte == exp_byte);
      end
   end

endmodule : swk_payload_compare

// ### swk_wake_payload.sv
// Wake frame length code, expected payload and tolerant-mode configuration
`timescale 1ns/1ps
module swk_wake_payload (
   input  wire logic            ref_clk,
   input  wire logic            arst_n,
   input  wire logic            soft_reset,
   input  wire swk_pkg::swk_req_t reg_req,
   output logic [15:0]          reg_rdata,
   output logic                 reg_rvalid,
   input  wire logic            silence_expired,
   input  wire logic            frame_start,
   input  wire swk_pkg::swk_len_t rx_len,
   input  wire logic            rx_byte_valid,
   input  wire logic [7:0]      rx_byte,
   input  wire logic            frame_end,
   output logic                 wake_match,
   output logic                 fd_tolerant_enable,
   output logic [2:0]           dominant_filter_time,
   output logic [3:0]           filter_cycles,
   output logic                 error_counter_suppress,
   output logic                 error_counter_hold,
   output logic                 wake_receiver_select
);
   import swk_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [3:0] bytes_of(input logic [3:0] code);
      bytes_of = (code >= LEN_CODE_MAX) ? BYTE_COUNT_MAX : code;
   endfunction : bytes_of

   function automatic logic [15:0] merge_wr(input logic [15:0] old, input logic hit,
                                            input logic [15:0] wd);
      merge_wr = hit ? wd : old;
   endfunction : merge_wr

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [3:0]  len_code_reg;
   logic [15:0] pay_76_reg;
   logic [15:0] pay_54_reg;
   logic [15:0] pay_32_reg;
   logic [15:0] pay_10_reg;
   logic        fd_en_reg;
   logic [2:0]  filter_reg;
   logic        suppress_reg;
   logic        rx_sel_reg;
   logic        len_ok_reg;
   logic [15:0] rdata_reg;
   logic        rvalid_reg;
   logic        match_reg;
   logic [3:0]  fcyc_reg;
   logic        hold_reg;

   logic [3:0]  len_code_next;
   logic [15:0] pay_76_next;
   logic [15:0] pay_54_next;
   logic [15:0] pay_32_next;
   logic [15:0] pay_10_next;
   logic        fd_en_next;
   logic [2:0]  filter_next;
   logic        suppress_next;
   logic        rx_sel_next;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire logic hit_len;
   wire logic hit_76;
   wire logic hit_54;
   wire logic hit_32;
   wire logic hit_10;
   wire logic hit_fd;
   wire logic hit_rx;
   wire logic [15:0] wd;

   assign wd     = reg_req.wdata;
   assign hit_len = reg_req.wr && (reg_req.addr == ADDR_LENGTH_CODE);
   assign hit_76  = reg_req.wr && (reg_req.addr == ADDR_PAYLOAD_7_6);
   assign hit_54  = reg_req.wr && (reg_req.addr == ADDR_PAYLOAD_5_4);
   assign hit_32  = reg_req.wr && (reg_req.addr == ADDR_PAYLOAD_3_2);
   assign hit_10  = reg_req.wr && (reg_req.addr == ADDR_PAYLOAD_1_0);
   assign hit_fd  = reg_req.wr && (reg_req.addr == ADDR_FD_TOLERANCE);
   assign hit_rx  = reg_req.wr && (reg_req.addr == ADDR_RX_SELECT);

   // ----------------------------------------
   // Next values
   // ----------------------------------------
   assign len_code_next = hit_len ? wd[LEN_CODE_MSB:0] : len_code_reg;
   assign pay_76_next   = merge_wr(pay_76_reg, hit_76, wd);
   assign pay_54_next   = merge_wr(pay_54_reg, hit_54, wd);
   assign pay_32_next   = merge_wr(pay_32_reg, hit_32, wd);
   assign pay_10_next   = merge_wr(pay_10_reg, hit_10, wd);
   assign fd_en_next    = hit_fd ? wd[FD_ENABLE_BIT] : fd_en_reg;
   assign filter_next   = hit_fd ? wd[DOMINANT_FILTER_TIME_MSB:DOMINANT_FILTER_TIME_LSB] : filter_reg;
   // Hardware clear at silence timeout overrides a write in the same cycle
   assign suppress_next = silence_expired ? 1'b0 :
                          (hit_fd ? wd[FD_SUPPRESS_BIT] : suppress_reg);
   assign rx_sel_next   = hit_rx ? wd[RX_SELECT_BIT] : rx_sel_reg;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         len_code_reg <= 4'h0;
         pay_76_reg   <= REG_RESET;
         pay_54_reg   <= REG_RESET;
         pay_32_reg   <= REG_RESET;
         pay_10_reg   <= REG_RESET;
         fd_en_reg    <= 1'b0;
         filter_reg   <= 3'h0;
         suppress_reg <= 1'b0;
         rx_sel_reg   <= 1'b0;
      end else if (soft_reset) begin
         len_code_reg <= 4'h0;
         pay_76_reg   <= REG_RESET;
         pay_54_reg   <= REG_RESET;
         pay_32_reg   <= REG_RESET;
         pay_10_reg   <= REG_RESET;
         fd_en_reg    <= 1'b0;
         filter_reg   <= 3'h0;
         suppress_reg <= 1'b0;
         rx_sel_reg   <= 1'b0;
      end else begin
         len_code_reg <= len_code_next;
         pay_76_reg   <= pay_76_next;
         pay_54_reg   <= pay_54_next;
         pay_32_reg   <= pay_32_next;
         pay_10_reg   <= pay_10_next;
         fd_en_reg    <= fd_en_next;
         filter_reg   <= filter_next;
         suppress_reg <= suppress_next;
         rx_sel_reg   <= rx_sel_next;
      end
   end

   // ----------------------------------------
   // Read-back
   // ----------------------------------------
   logic [15:0] rd_mux;

   always_comb begin
      rd_mux = 16'h0000;
      case (reg_req.addr)
         ADDR_LENGTH_CODE:  rd_mux = {12'h000, len_code_reg};
         ADDR_PAYLOAD_7_6:  rd_mux = pay_76_reg;
         ADDR_PAYLOAD_5_4:  rd_mux = pay_54_reg;
         ADDR_PAYLOAD_3_2:  rd_mux = pay_32_reg;
         ADDR_PAYLOAD_1_0:  rd_mux = pay_10_reg;
         ADDR_FD_TOLERANCE: rd_mux = {10'h000, suppress_reg, 1'b0, filter_reg, fd_en_reg};
         ADDR_RX_SELECT:    rd_mux = {1'b0, rx_sel_reg, 14'h0000};
         default:           rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg  <= 16'h0000;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg  <= reg_req.rd ? rd_mux : rdata_reg;
         rvalid_reg <= reg_req.rd;
      end
   end

   // ----------------------------------------
   // Frame matching
   // ----------------------------------------
   wire logic [63:0] expected;
   wire logic        pay_match;
   wire logic [3:0]  fcyc;

   assign expected = {pay_76_reg, pay_54_reg, pay_32_reg, pay_10_reg};

   swk_payload_compare u_cmp (
      .ref_clk       (ref_clk),
      .arst_n        (arst_n),
      .frame_start   (frame_start),
      .byte_count    (bytes_of(len_code_reg)),
      .expected      (expected),
      .rx_byte_valid (rx_byte_valid),
      .rx_byte       (rx_byte),
      .all_match     (pay_match),
      .byte_index    ()
   );

   swk_filter_time u_filt (
      .filter_code   (filter_reg),
      .filter_ns     (),
      .filter_cycles (fcyc)
   );

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         len_ok_reg <= 1'b0;
         match_reg  <= 1'b0;
         fcyc_reg   <= 4'h0;
         hold_reg   <= 1'b0;
      end else begin
         if (frame_start) begin
            len_ok_reg <= 1'b0;
         end else if (rx_len.valid) begin
            len_ok_reg <= (rx_len.len_code == len_code_reg);
         end
         match_reg <= frame_end && len_ok_reg && pay_match;
         fcyc_reg  <= fcyc;
         hold_reg  <= !soft_reset && suppress_next && fd_en_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign reg_rdata              = rdata_reg;
   assign reg_rvalid             = rvalid_reg;
   assign wake_match             = match_reg;
   assign fd_tolerant_enable     = fd_en_reg;
   assign dominant_filter_time   = filter_reg;
   assign filter_cycles          = fcyc_reg;
   assign error_counter_suppress = suppress_reg;
   assign error_counter_hold     = hold_reg;
   assign wake_receiver_select   = rx_sel_reg;

endmodule : swk_wake_payload

// ### swk_wake_payload_properties.sv
// Concurrent checks on the ports of the wake payload block
`timescale 1ns/1ps
module swk_wake_payload_properties (
   input wire logic              ref_clk,
   input wire logic              arst_n,
   input wire logic              soft_reset,
   input wire swk_pkg::swk_req_t reg_req,
   input wire logic [15:0]       reg_rdata,
   input wire logic              reg_rvalid,
   input wire logic              silence_expired,
   input wire logic              frame_end,
   input wire logic              wake_match,
   input wire logic              fd_tolerant_enable,
   input wire logic [2:0]        dominant_filter_time,
   input wire logic              error_counter_suppress,
   input wire logic              error_counter_hold,
   input wire logic              wake_receiver_select
);
   import swk_pkg::*;
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);
   wire logic wr_ok = reg_req.wr && !soft_reset;
   wire logic fd_wr = wr_ok && reg_req.addr == ADDR_FD_TOLERANCE;
   len_read_a: assert property (reg_req.rd && reg_req.addr == ADDR_LENGTH_CODE
      |=> reg_rvalid && reg_rdata[15:4] == 12'h000) else $error("length upper bits not zero");
   fd_enable_a: assert property (fd_wr |=> fd_tolerant_enable == $past(reg_req.wdata[0]))
      else $error("tolerant enable not written");
   filter_set_a: assert property (fd_wr |=> dominant_filter_time == $past(reg_req.wdata[3:1]))
      else $error("filter field not written");
   suppress_set_a: assert property (fd_wr && !silence_expired
      |=> error_counter_suppress == $past(reg_req.wdata[5])) else $error("suppress not written");
   hold_gate_a: assert property (error_counter_hold ==
      (error_counter_suppress && fd_tolerant_enable)) else $error("hold not gated by enable");
   silence_clear_a: assert property (silence_expired |=> !error_counter_suppress)
      else $error("suppress survived silence");
   rx_select_a: assert property (wr_ok && reg_req.addr == ADDR_RX_SELECT
      |=> wake_receiver_select == $past(reg_req.wdata[14])) else $error("receiver select wrong");
   soft_clear_a: assert property (soft_reset |=> !fd_tolerant_enable && !wake_receiver_select
      && dominant_filter_time == 3'h0 && !error_counter_suppress && !error_counter_hold)
      else $error("soft reset missed");
   match_cause_a: assert property (wake_match |-> $past(frame_end))
      else $error("match without frame end");
   cover property (wake_match);
   cover property (error_counter_hold);
   cover property (silence_expired && error_counter_suppress);
endmodule : swk_wake_payload_properties

bind swk_wake_payload swk_wake_payload_properties u_props (.ref_clk, .arst_n, .soft_reset,
   .reg_req, .reg_rdata, .reg_rvalid, .silence_expired, .frame_end, .wake_match,
   .fd_tolerant_enable, .dominant_filter_time, .error_counter_suppress, .error_counter_hold,
   .wake_receiver_select);

// ### swk_can_node.sv
// Bus node model that delivers decoded wake frames
`timescale 1ns/1ps
module swk_can_node (
   input  wire logic        ref_clk,
   output logic             frame_start,
   output swk_pkg::swk_len_t rx_len,
   output logic             rx_byte_valid,
   output logic [7:0]       rx_byte,
   output logic             frame_end
);
   import swk_pkg::*;
   initial begin
      frame_start = 1'b0;
      rx_len = '0;
      rx_byte_valid = 1'b0;
      rx_byte = 8'h00;
      frame_end = 1'b0;
   end
   // Gap cycles between bytes show a changing value
   task automatic send(input logic [3:0] code, input int n, input logic [63:0] d,
                       input logic flip, input int gap);
      @(posedge ref_clk);
      frame_start <= 1'b1;
      @(posedge ref_clk);
      frame_start <= 1'b0;
      rx_len <= '{1'b1, code};
      for (int k = 0; k < n; k++) begin
         @(posedge ref_clk);
         rx_len.valid <= 1'b0;
         rx_byte_valid <= 1'b1;
         rx_byte <= d[8*k +: 8] ^ ((flip && k == n - 1) ? 8'hff : 8'h00);
         repeat (gap) begin
            @(posedge ref_clk);
            rx_byte_valid <= 1'b0;
            rx_byte <= ~rx_byte;
         end
      end
      @(posedge ref_clk);
      rx_len.valid <= 1'b0;
      rx_byte_valid <= 1'b0;
      rx_byte <= ~rx_byte;
      frame_end <= 1'b1;
      @(posedge ref_clk);
      frame_end <= 1'b0;
   endtask : send
endmodule : swk_can_node

// ### test_wake_frame_payload_config.sv
// Self-checking testbench of the wake payload block
`timescale 1ns/1ps
module test_wake_frame_payload_config;
   import swk_pkg::*;
   logic        ref_clk, arst_n, soft_reset, silence_expired, rvalid, frame_start, byte_v;
   logic        frame_end, wake_match, fd_en, sup, hold, rxsel;
   swk_req_t    reg_req;
   swk_len_t    rx_len;
   logic [15:0] rdata;
   logic [7:0]  rx_byte;
   logic [2:0]  filt;
   logic [3:0]  fcyc;
   int          bad_count, n_compared;
   localparam logic [63:0] PAY = 64'ha5c3_3c81_7e19_d24b;
   localparam logic [6:0] ADR [7] = '{ADDR_LENGTH_CODE, ADDR_PAYLOAD_7_6, ADDR_PAYLOAD_5_4,
      ADDR_PAYLOAD_3_2, ADDR_PAYLOAD_1_0, ADDR_FD_TOLERANCE, ADDR_RX_SELECT};

   swk_wake_payload DUT (.ref_clk, .arst_n, .soft_reset, .reg_req, .reg_rdata(rdata),
      .reg_rvalid(rvalid), .silence_expired, .frame_start, .rx_len, .rx_byte_valid(byte_v),
      .rx_byte, .frame_end, .wake_match, .fd_tolerant_enable(fd_en), .dominant_filter_time(filt),
      .filter_cycles(fcyc), .error_counter_suppress(sup), .error_counter_hold(hold),
      .wake_receiver_select(rxsel));
   swk_can_node node (.ref_clk, .frame_start, .rx_len, .rx_byte_valid(byte_v), .rx_byte,
      .frame_end);

   // ----------------------------------------
   // Bus and compare tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_req <= '{1'b1, 1'b0, a, d};
      @(posedge ref_clk);
      reg_req <= '0;
      #1;
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      reg_req <= '{1'b0, 1'b1, a, 16'h0000};
      @(posedge ref_clk);
      reg_req <= '0;
      #1;
      check({15'h0000, rvalid}, 16'h0001, "rvalid");
      check(rdata, exp, "rdata");
   endtask : rd
   task automatic frame(input logic [3:0] c, input int n, input logic f, input int g,
                        input logic exp);
      node.send(c, n, PAY, f, g);
      #1;
      check({15'h0000, wake_match}, {15'h0000, exp}, "match");
   endtask : frame
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      foreach (ADR[i]) rd(ADR[i], 16'h0000);
      wr(ADDR_LENGTH_CODE, 16'hfff5);
      rd(ADDR_LENGTH_CODE, 16'h0005);
      for (int i = 0; i < 4; i++) wr(ADR[i+1], PAY[63-16*i -: 16]);
      for (int i = 0; i < 4; i++) rd(ADR[i+1], PAY[63-16*i -: 16]);
      wr(ADDR_FD_TOLERANCE, 16'hffff);
      rd(ADDR_FD_TOLERANCE, 16'h002f);
      wr(7'h40, 16'h1234);
      rd(7'h40, 16'h0000);
      wr(ADDR_RX_SELECT, 16'h4000);
      check({15'h0000, rxsel}, 16'h0001, "rx select");
   endtask : t_regs
   task automatic t_filter;
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_FD_TOLERANCE, {12'h000, c[2:0], 1'b1});
         @(posedge ref_clk);
         #1;
         check({13'h0000, filt}, {13'h0000, c[2:0]}, "filter");
         check({12'h000, fcyc}, (c == 7) ? 16'h0008 : 16'(c / 2 + 1), "cycles");
      end
   endtask : t_filter
   task automatic t_suppress;
      wr(ADDR_FD_TOLERANCE, 16'h0021);
      check({13'h0000, fd_en, sup, hold}, 16'h0007, "hold on");
      wr(ADDR_FD_TOLERANCE, 16'h0020);
      check({13'h0000, fd_en, sup, hold}, 16'h0002, "hold gated");
      @(posedge ref_clk);
      silence_expired <= 1'b1;
      @(posedge ref_clk);
      silence_expired <= 1'b0;
      rd(ADDR_FD_TOLERANCE, 16'h0000);
      @(posedge ref_clk);
      silence_expired <= 1'b1;
      reg_req <= '{1'b1, 1'b0, ADDR_FD_TOLERANCE, 16'h0021};
      @(posedge ref_clk);
      silence_expired <= 1'b0;
      reg_req <= '0;
      #1;
      check({13'h0000, fd_en, sup, hold}, 16'h0004, "clear beats write");
   endtask : t_suppress
   task automatic t_frames;
      int n;
      for (int c = 0; c < 16; c++) begin
         n = (c > 8) ? 8 : c;
         wr(ADDR_LENGTH_CODE, 16'(c));
         frame(c[3:0], n, 1'b0, c % 3, 1'b1);
         frame(c[3:0] ^ 4'h1, n, 1'b0, 0, 1'b0);
         if (n > 0) frame(c[3:0], n, 1'b1, 0, 1'b0);
         if (n > 0) frame(c[3:0], n - 1, 1'b0, 1, 1'b0);
      end
   endtask : t_frames
   task automatic t_soft;
      wr(ADDR_FD_TOLERANCE, 16'h0021);
      @(posedge ref_clk);
      soft_reset <= 1'b1;
      @(posedge ref_clk);
      soft_reset <= 1'b0;
      #1;
      check({13'h0000, fd_en, sup, hold}, 16'h0000, "soft cleared flags");
      foreach (ADR[i]) rd(ADR[i], 16'h0000);
      check({15'h0000, rxsel}, 16'h0000, "rx select cleared");
   endtask : t_soft

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      $display("[FAIL] %0t run did not finish", $time);
      report_and_stop();
   end
   initial begin
      arst_n = 1'b0;
      soft_reset = 1'b0;
      silence_expired = 1'b0;
      reg_req = '0;
      bad_count = 0;
      n_compared = 0;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_regs();
      t_filter();
      t_suppress();
      t_frames();
      t_soft();
      report_and_stop();
   end
endmodule : test_wake_frame_payload_config
